// ===== hdl/irq_status_defines.svh
// Register offsets, bit positions, masks and reset values of the interrupt status collector.
// Assumes it is included by bare name from the design files.
`ifndef IRQ_STATUS_DEFINES_SVH
`define IRQ_STATUS_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_INTERRUPT_STATUS 8'h58
`define OFS_INTERRUPT_ENABLE 8'h5C
`define OFS_BYTE_TEST        8'h64
`define OFS_FIFO_LEVEL       8'h68

// ----------------------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------------------
`define BIT_SOFTWARE         31
`define BIT_TX_HALTED        25
`define BIT_RX_HALTED        24
`define BIT_DROP_MIDPOINT    23
`define BIT_TX_LOADED        21
`define BIT_RX_DMA           20
`define BIT_TIMER_WRAP       19
`define BIT_TRANSCEIVER      18
`define BIT_POWER_EVENT      17
`define BIT_TX_STATUS_OVF    16
`define BIT_RX_WATCHDOG      15
`define BIT_RX_ERROR         14
`define BIT_TX_ERROR         13
`define BIT_TX_DATA_OVERRUN  10
`define BIT_TX_SPACE         9
`define BIT_TX_STATUS_FULL   8
`define BIT_TX_STATUS_LEVEL  7
`define BIT_RX_DROPPED       6
`define BIT_RX_STATUS_FULL   4
`define BIT_RX_STATUS_LEVEL  3
`define BIT_PIN_HI           2
`define BIT_PIN_LO           0

// ----------------------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------------------
`define STATUS_CLEAR_MASK    32'h83BBE7DF
`define STATUS_READ_MASK     32'h83BFE7DF
`define STATUS_RESET         32'h00000000
`define ENABLE_RESET         32'h00000000
`define FIFO_LEVEL_RESET     32'h48000000
`define FIFO_LEVEL_MASK      32'hFFFF00FF
`define BYTE_TEST_VALUE      32'h87654321
`define READ_IDLE            32'h00000000

// ----------------------------------------------------------------------------
// Event thresholds and FIFO level fields
// ----------------------------------------------------------------------------
`define DROP_MID_LO          32'h7FFFFFFF
`define DROP_MID_HI          32'h80000000
`define TIMER_ZERO           16'h0000
`define TIMER_WRAP           16'hFFFF
`define RX_WATCHDOG_BYTES    16'h0800
`define TX_AVAIL_MSB         31
`define TX_AVAIL_LSB         24
`define TX_STS_LEVEL_MSB     23
`define TX_STS_LEVEL_LSB     16
`define RX_STS_LEVEL_MSB     7
`define RX_STS_LEVEL_LSB     0

`endif

// ===== hdl/irq_status_pkg.sv
// Types shared by the interrupt status collector.
// Assumes the defines header supplies all numeric constants.
package irq_status_pkg;

  typedef logic [31:0] word_type;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_STATUS,
    SEL_ENABLE,
    SEL_BYTE_TEST,
    SEL_FIFO_LEVEL
  } reg_sel_type;

endpackage

// ===== hdl/interrupt_status_collector.sv
// Interrupt status collector: sticky event flags, enable mask and register port.
// Assumes event inputs are synchronous to i_clk and the host uses the plain register port.
//
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
`include "irq_status_defines.svh"

module interrupt_status_collector #(
  parameter int ADDR_WIDTH = 8,
  parameter int LEN_WIDTH  = 16,
  parameter int PIN_COUNT  = 3
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst,
  input  wire logic [ADDR_WIDTH-1:0]     i_addr,
  input  wire irq_status_pkg::word_type  i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output irq_status_pkg::word_type       o_rdata,
  input  wire logic                      i_stop_tx_request,
  input  wire logic                      i_tx_halted,
  input  wire logic                      i_rx_halted,
  input  wire irq_status_pkg::word_type  i_drop_count,
  input  wire logic                      i_tx_buffer_loaded,
  input  wire logic                      i_completion_notify,
  input  wire logic                      i_rx_dma_done,
  input  wire logic [15:0]               i_timer_value,
  input  wire logic                      i_transceiver_event,
  input  wire logic                      i_power_event,
  input  wire logic                      i_tx_status_overflow,
  input  wire logic                      i_rx_frame_done,
  input  wire logic [LEN_WIDTH-1:0]      i_rx_frame_length,
  input  wire logic                      i_rx_error,
  input  wire logic                      i_tx_error,
  input  wire logic                      i_tx_data_write,
  input  wire logic                      i_tx_data_full,
  input  wire logic [7:0]                i_tx_free_blocks,
  input  wire logic                      i_tx_status_full,
  input  wire logic [7:0]                i_tx_status_used,
  input  wire logic                      i_rx_frame_dropped,
  input  wire logic                      i_rx_status_full,
  input  wire logic [7:0]                i_rx_status_used,
  input  wire logic [PIN_COUNT-1:0]      i_pin_events,
  output logic                           o_irq_internal,
  output logic                           o_irq_holdable,
  output logic                           o_irq_power,
  output logic                           o_wake
);
  import irq_status_pkg::*;

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  word_type              status_r;
  word_type              status_nxt;
  word_type              enable_r;
  word_type              enable_nxt;
  word_type              fifo_level_r;
  word_type              fifo_level_nxt;
  word_type              rdata_r;
  word_type              rdata_nxt;
  word_type              drop_prev_r;
  logic [15:0]           timer_prev_r;
  logic                  wake_r;

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  reg_sel_type           sel;
  wire logic             hit_status;
  wire logic             hit_enable;
  wire logic             hit_test;
  wire logic             hit_fifo;

  assign hit_status = (i_addr == `OFS_INTERRUPT_STATUS);
  assign hit_enable = (i_addr == `OFS_INTERRUPT_ENABLE);
  assign hit_test   = (i_addr == `OFS_BYTE_TEST);
  assign hit_fifo   = (i_addr == `OFS_FIFO_LEVEL);

  always_comb begin
    if (hit_status) begin
      sel = SEL_STATUS;
    end else if (hit_enable) begin
      sel = SEL_ENABLE;
    end else if (hit_test) begin
      sel = SEL_BYTE_TEST;
    end else if (hit_fifo) begin
      sel = SEL_FIFO_LEVEL;
    end else begin
      sel = SEL_NONE;
    end
  end

  wire logic             wr_status;
  wire logic             wr_enable;
  wire logic             wr_test;
  wire logic             wr_fifo;

  assign wr_status = i_wr && (sel == SEL_STATUS);
  assign wr_enable = i_wr && (sel == SEL_ENABLE);
  assign wr_test   = i_wr && (sel == SEL_BYTE_TEST);
  assign wr_fifo   = i_wr && (sel == SEL_FIFO_LEVEL);

  // --------------------------------------------------------------------------
  // Event detection
  // --------------------------------------------------------------------------
  wire logic [7:0]       tx_avail_level;
  wire logic [7:0]       tx_sts_level;
  wire logic [7:0]       rx_sts_level;
  wire logic             sw_enable_rise;
  wire logic             drop_midpoint;
  wire logic             timer_wrap;
  wire logic             rx_too_long;
  word_type              set_vec;
  word_type              clear_vec;
  word_type              status_view;

  assign tx_avail_level = fifo_level_r[`TX_AVAIL_MSB:`TX_AVAIL_LSB];
  assign tx_sts_level   = fifo_level_r[`TX_STS_LEVEL_MSB:`TX_STS_LEVEL_LSB];
  assign rx_sts_level   = fifo_level_r[`RX_STS_LEVEL_MSB:`RX_STS_LEVEL_LSB];

  // The software flag fires when the enable goes from clear to set by a write.
  assign sw_enable_rise = wr_enable && i_wdata[`BIT_SOFTWARE] && !enable_r[`BIT_SOFTWARE];
  assign drop_midpoint  = (drop_prev_r == `DROP_MID_LO) && (i_drop_count == `DROP_MID_HI);
  assign timer_wrap     = (timer_prev_r == `TIMER_ZERO) && (i_timer_value == `TIMER_WRAP);
  assign rx_too_long    = i_rx_frame_done
                          && (i_rx_frame_length > LEN_WIDTH'(`RX_WATCHDOG_BYTES));

  // Every flag is fed from its source alone; the enable mask is consulted only for the software flag's rise.
  always_comb begin
    set_vec                        = `STATUS_RESET;
    set_vec[`BIT_SOFTWARE]         = sw_enable_rise;
    set_vec[`BIT_TX_HALTED]        = i_stop_tx_request && i_tx_halted;
    set_vec[`BIT_RX_HALTED]        = i_rx_halted;
    set_vec[`BIT_DROP_MIDPOINT]    = drop_midpoint;
    set_vec[`BIT_TX_LOADED]        = i_tx_buffer_loaded && i_completion_notify;
    set_vec[`BIT_RX_DMA]           = i_rx_dma_done;
    set_vec[`BIT_TIMER_WRAP]       = timer_wrap;
    set_vec[`BIT_POWER_EVENT]      = i_power_event;
    set_vec[`BIT_TX_STATUS_OVF]    = i_tx_status_overflow;
    set_vec[`BIT_RX_WATCHDOG]      = rx_too_long;
    set_vec[`BIT_RX_ERROR]         = i_rx_error;
    set_vec[`BIT_TX_ERROR]         = i_tx_error;
    set_vec[`BIT_TX_DATA_OVERRUN]  = i_tx_data_write && i_tx_data_full;
    set_vec[`BIT_TX_SPACE]         = (i_tx_free_blocks > tx_avail_level);
    set_vec[`BIT_TX_STATUS_FULL]   = i_tx_status_full;
    set_vec[`BIT_TX_STATUS_LEVEL]  = (i_tx_status_used > tx_sts_level);
    set_vec[`BIT_RX_DROPPED]       = i_rx_frame_dropped;
    set_vec[`BIT_RX_STATUS_FULL]   = i_rx_status_full;
    set_vec[`BIT_RX_STATUS_LEVEL]  = (i_rx_status_used > rx_sts_level);
    set_vec[`BIT_PIN_HI:`BIT_PIN_LO] = i_pin_events;
  end

  // Only defined write-one-to-clear bits react to a write; bit 18 and reserved bits do not.
  assign clear_vec = wr_status ? (i_wdata & `STATUS_CLEAR_MASK) : `STATUS_RESET;

  // A new event in the clearing cycle keeps its flag set.
  assign status_nxt = ((status_r & ~clear_vec) | set_vec) & `STATUS_CLEAR_MASK;

  // The transceiver bit is a live view of its source and is never stored.
  always_comb begin
    status_view                    = status_r;
    status_view[`BIT_TRANSCEIVER]  = i_transceiver_event;
  end

  assign enable_nxt     = wr_enable ? (i_wdata & `STATUS_READ_MASK) : enable_r;
  assign fifo_level_nxt = wr_fifo ? (i_wdata & `FIFO_LEVEL_MASK) : fifo_level_r;

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  always_comb begin
    rdata_nxt = `READ_IDLE;
    if (i_rd) begin
      case (sel)
        SEL_STATUS:     rdata_nxt = status_view & `STATUS_READ_MASK;
        SEL_ENABLE:     rdata_nxt = enable_r;
        SEL_BYTE_TEST:  rdata_nxt = `BYTE_TEST_VALUE;
        SEL_FIFO_LEVEL: rdata_nxt = fifo_level_r;
        default:        rdata_nxt = `READ_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      status_r     <= `STATUS_RESET;
      enable_r     <= `ENABLE_RESET;
      fifo_level_r <= `FIFO_LEVEL_RESET;
      rdata_r      <= `READ_IDLE;
      drop_prev_r  <= `DROP_MID_HI;
      timer_prev_r <= `TIMER_WRAP;
      wake_r       <= 1'b0;
    end else begin
      status_r     <= status_nxt;
      enable_r     <= enable_nxt;
      fifo_level_r <= fifo_level_nxt;
      rdata_r      <= rdata_nxt;
      drop_prev_r  <= i_drop_count;
      timer_prev_r <= i_timer_value;
      wake_r       <= wr_test;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  wire word_type         pending;

  assign pending        = status_view & enable_r;
  assign o_irq_internal = |pending;
  // The power event leaves on its own line so the hold-off timer cannot delay it.
  assign o_irq_holdable = |(pending & ~(32'h00000001 << `BIT_POWER_EVENT));
  assign o_irq_power    = pending[`BIT_POWER_EVENT];
  assign o_rdata        = rdata_r;
  assign o_wake         = wake_r;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  status_read_a: assert property (
    i_rd && hit_status |=> o_rdata == ($past(status_view) & `STATUS_READ_MASK))
    else $error("status read data wrong");

  clear_write_a: assert property (
    wr_status && i_wdata[`BIT_RX_ERROR] && !i_rx_error |=> !status_r[`BIT_RX_ERROR])
    else $error("written one did not clear flag");

  sw_raise_a: assert property (
    wr_enable && i_wdata[`BIT_SOFTWARE] && !enable_r[`BIT_SOFTWARE]
    |=> status_r[`BIT_SOFTWARE] && enable_r[`BIT_SOFTWARE])
    else $error("software flag not raised");

  tx_halt_a: assert property (
    i_stop_tx_request && i_tx_halted |=> status_r[`BIT_TX_HALTED])
    else $error("transmit halted flag missing");

  drop_mid_a: assert property (
    ##1 ($past(i_drop_count) == `DROP_MID_LO) && (i_drop_count == `DROP_MID_HI)
    |=> status_r[`BIT_DROP_MIDPOINT])
    else $error("midpoint crossing missed");

  timer_wrap_a: assert property (
    ##1 ($past(i_timer_value) == `TIMER_ZERO) && (i_timer_value == `TIMER_WRAP)
    |=> status_r[`BIT_TIMER_WRAP])
    else $error("timer wrap missed");

  phy_ro_a: assert property (
    i_rd && hit_status |=> o_rdata[`BIT_TRANSCEIVER] == $past(i_transceiver_event))
    else $error("transceiver bit not live");

  wake_write_a: assert property (
    o_wake |-> $past(i_wr) && $past(i_addr) == `OFS_BYTE_TEST)
    else $error("wake without byte test write");

  power_bypass_a: assert property (
    status_r[`BIT_POWER_EVENT] && enable_r[`BIT_POWER_EVENT] |-> o_irq_power && o_irq_internal)
    else $error("power event held off");

  watchdog_a: assert property (
    i_rx_frame_done && i_rx_frame_length == LEN_WIDTH'(`RX_WATCHDOG_BYTES)
    && !status_r[`BIT_RX_WATCHDOG] |=> !status_r[`BIT_RX_WATCHDOG])
    else $error("watchdog flag on exact 2048 bytes");

  overrun_a: assert property (
    i_tx_data_write && i_tx_data_full |=> status_r[`BIT_TX_DATA_OVERRUN])
    else $error("overrun flag missing");

  reserved_a: assert property (
    i_rd |=> (o_rdata & ~`STATUS_READ_MASK) == `READ_IDLE || !$past(hit_status))
    else $error("reserved status bit read nonzero");

  masked_record_a: assert property (
    i_rx_frame_dropped && !enable_r[`BIT_RX_DROPPED] |=> status_r[`BIT_RX_DROPPED])
    else $error("masked event not recorded");

  master_a: assert property (
    o_irq_internal == ((status_view & enable_r) != `STATUS_RESET))
    else $error("master indication mismatch");

  sticky_a: assert property (
    status_r[`BIT_PIN_LO] && !(wr_status && i_wdata[`BIT_PIN_LO])
    |=> status_r[`BIT_PIN_LO])
    else $error("sticky flag dropped");

  set_wins_a: assert property (
    wr_status && i_wdata[`BIT_RX_DROPPED] && i_rx_frame_dropped |=> status_r[`BIT_RX_DROPPED])
    else $error("set lost to clear");

  rx_halt_a: assert property (
    i_rx_halted |=> status_r[`BIT_RX_HALTED])
    else $error("receive halted flag missing");

  power_clear_a: assert property (
    wr_status && i_wdata[`BIT_POWER_EVENT] && !i_power_event |=> !status_r[`BIT_POWER_EVENT])
    else $error("power flag not cleared");

  space_level_a: assert property (
    i_tx_free_blocks == tx_avail_level && !status_r[`BIT_TX_SPACE] |=> !status_r[`BIT_TX_SPACE])
    else $error("space flag raised at equal level");

  pin_event_a: assert property (
    i_pin_events[`BIT_PIN_HI] |=> status_r[`BIT_PIN_HI])
    else $error("pin event not captured");

  clear_cover_c: cover property (status_r[`BIT_RX_ERROR] ##1 wr_status ##1 !status_r[`BIT_RX_ERROR]);
  wake_cover_c: cover property (status_r[`BIT_POWER_EVENT] ##[1:20] o_wake);
  collide_cover_c: cover property (wr_status && (set_vec & i_wdata) != `STATUS_RESET);
  irq_cover_c: cover property (!o_irq_internal ##1 o_irq_internal);

endmodule

// ===== tb/host_bus_model.sv
// Host software model that reaches the collector's registers over the plain register port.
// Assumes a single caller at a time and read data standing only in the cycle after the strobe.
`timescale 1ns/100ps

module host_bus_model #(
  parameter int ADDR_WIDTH = 8
) (
  input  wire logic                     i_clk,
  output logic [ADDR_WIDTH-1:0]         o_addr,
  output irq_status_pkg::word_type      o_wdata,
  output logic                          o_wr,
  output logic                          o_rd,
  input  wire irq_status_pkg::word_type i_rdata
);
  import irq_status_pkg::*;

  initial begin
    o_addr  = '0;
    o_wdata = '0;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end

  // --------------------------------------------------------------------------
  // Bus cycles
  // --------------------------------------------------------------------------
  // Released lines get the inverse so a stale value never looks valid.
  task automatic bus_write(input logic [ADDR_WIDTH-1:0] addr, input word_type data);
    @(posedge i_clk);
    o_wr    <= 1'b1;
    o_addr  <= addr;
    o_wdata <= data;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_addr  <= ~addr;
    o_wdata <= ~data;
  endtask

  task automatic bus_read(input logic [ADDR_WIDTH-1:0] addr, output word_type data);
    @(posedge i_clk);
    o_rd   <= 1'b1;
    o_addr <= addr;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    o_addr <= ~addr;
    #1;
    data = i_rdata;
  endtask

endmodule

// ===== tb/interrupt_status_collector_tb.sv
// Self-checking bench of the interrupt status collector.
// Assumes the host model drives the register port and this module drives every event input.
`timescale 1ns/100ps
`include "irq_status_defines.svh"

module interrupt_status_collector_tb;
  import irq_status_pkg::*;

  logic        i_clk, i_rst, i_wr, i_rd, i_stop_tx_request, i_tx_halted, i_rx_halted;
  logic        i_tx_buffer_loaded, i_completion_notify, i_rx_dma_done, i_transceiver_event;
  logic        i_power_event, i_tx_status_overflow, i_rx_frame_done, i_rx_error, i_tx_error;
  logic        i_tx_data_write, i_tx_data_full, i_tx_status_full, i_rx_frame_dropped;
  logic        i_rx_status_full, o_irq_internal, o_irq_holdable, o_irq_power, o_wake;
  logic [7:0]  i_addr, i_tx_free_blocks, i_tx_status_used, i_rx_status_used;
  logic [15:0] i_timer_value, i_rx_frame_length;
  logic [2:0]  i_pin_events;
  word_type    i_wdata, o_rdata, i_drop_count, rv;
  int          fails, checks;
  int          src_bits[$] = '{25, 24, 23, 21, 20, 19, 17, 16, 15, 14, 13, 10, 9, 8, 7, 6, 4, 3,
                               2, 1, 0};

  interrupt_status_collector i_interrupt_status_collector (
    .i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_stop_tx_request,
    .i_tx_halted, .i_rx_halted, .i_drop_count, .i_tx_buffer_loaded, .i_completion_notify,
    .i_rx_dma_done, .i_timer_value, .i_transceiver_event, .i_power_event,
    .i_tx_status_overflow, .i_rx_frame_done, .i_rx_frame_length, .i_rx_error, .i_tx_error,
    .i_tx_data_write, .i_tx_data_full, .i_tx_free_blocks, .i_tx_status_full,
    .i_tx_status_used, .i_rx_frame_dropped, .i_rx_status_full, .i_rx_status_used,
    .i_pin_events, .o_irq_internal, .o_irq_holdable, .o_irq_power, .o_wake
  );

  host_bus_model host (
    .i_clk(i_clk), .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd),
    .i_rdata(o_rdata)
  );

  always #50 i_clk = ~i_clk;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  task automatic check(input string name, input word_type seen, input word_type exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic expect_reg(input string name, input logic [7:0] addr, input word_type exp);
    host.bus_read(addr, rv);
    check(name, rv, exp);
  endtask

  // Drives one event source into its active (v=1) or idle (v=0) state.
  task automatic set_src(input int b, input logic v);
    case (b)
      25: begin i_stop_tx_request <= v; i_tx_halted <= v; end
      24: i_rx_halted <= v;
      23: i_drop_count <= v ? 32'h7FFFFFFF : 32'h80000000;
      21: begin i_tx_buffer_loaded <= v; i_completion_notify <= v; end
      20: i_rx_dma_done <= v;
      19: i_timer_value <= v ? 16'h0000 : 16'hFFFF;
      17: i_power_event <= v;
      16: i_tx_status_overflow <= v;
      15: begin i_rx_frame_done <= v; i_rx_frame_length <= v ? 16'h0801 : 16'h0000; end
      14: i_rx_error <= v;
      13: i_tx_error <= v;
      10: begin i_tx_data_write <= v; i_tx_data_full <= v; end
      9: i_tx_free_blocks <= v ? 8'h49 : 8'h00;
      8: i_tx_status_full <= v;
      7: i_tx_status_used <= v ? 8'h01 : 8'h00;
      6: i_rx_frame_dropped <= v;
      4: i_rx_status_full <= v;
      3: i_rx_status_used <= v ? 8'h01 : 8'h00;
      default: i_pin_events[b] <= v;
    endcase
  endtask

  task automatic pulse(input int b);
    @(posedge i_clk);
    set_src(b, 1'b1);
    @(posedge i_clk);
    set_src(b, 1'b0);
    #1;
  endtask

  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #1_000_000;
    fails++;
    $display("watchdog expired");
    end_sim();
  end

  // --------------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    i_rst = 1'b1;
    {i_stop_tx_request, i_tx_halted, i_rx_halted, i_tx_buffer_loaded} = '0;
    {i_completion_notify, i_rx_dma_done, i_transceiver_event, i_power_event} = '0;
    {i_tx_status_overflow, i_rx_frame_done, i_rx_error, i_tx_error, i_tx_data_write} = '0;
    {i_tx_data_full, i_tx_status_full, i_rx_frame_dropped, i_rx_status_full} = '0;
    {i_tx_free_blocks, i_tx_status_used, i_rx_status_used, i_pin_events} = '0;
    i_rx_frame_length = 16'h0000;
    i_drop_count = 32'h80000000;
    i_timer_value = 16'hFFFF;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    expect_reg("status", `OFS_INTERRUPT_STATUS, 32'h00000000);
    expect_reg("enable", `OFS_INTERRUPT_ENABLE, 32'h00000000);
    expect_reg("fifo level", `OFS_FIFO_LEVEL, 32'h48000000);
    expect_reg("byte test", `OFS_BYTE_TEST, 32'h87654321);
    expect_reg("unmapped", 8'h60, 32'h00000000);
    $display("test reset values done");

    foreach (src_bits[k]) begin
      pulse(src_bits[k]);
      expect_reg("event bit", `OFS_INTERRUPT_STATUS, 32'h1 << src_bits[k]);
      host.bus_write(`OFS_INTERRUPT_STATUS, 32'h1 << src_bits[k]);
      expect_reg("cleared bit", `OFS_INTERRUPT_STATUS, 32'h00000000);
    end
    $display("test event sources done");

    @(posedge i_clk);
    i_rx_frame_done <= 1'b1;
    i_rx_frame_length <= 16'h0800;
    i_tx_buffer_loaded <= 1'b1;
    i_tx_free_blocks <= 8'h48;
    i_tx_data_write <= 1'b1;
    @(posedge i_clk);
    {i_rx_frame_done, i_tx_buffer_loaded, i_tx_data_write} <= '0;
    i_tx_free_blocks <= 8'h00;
    expect_reg("boundaries", `OFS_INTERRUPT_STATUS, 32'h00000000);
    $display("test boundaries done");

    @(posedge i_clk);
    i_transceiver_event <= 1'b1;
    host.bus_write(`OFS_INTERRUPT_STATUS, 32'hFFFFFFFF);
    expect_reg("live bit", `OFS_INTERRUPT_STATUS, 32'h00040000);
    @(posedge i_clk);
    i_transceiver_event <= 1'b0;
    expect_reg("live bit off", `OFS_INTERRUPT_STATUS, 32'h00000000);
    $display("test read-only bits done");

    host.bus_write(`OFS_INTERRUPT_ENABLE, 32'h80000000);
    expect_reg("software bit", `OFS_INTERRUPT_STATUS, 32'h80000000);
    check("irq internal", {31'h0, o_irq_internal}, 32'h1);
    host.bus_write(`OFS_INTERRUPT_STATUS, 32'h80000000);
    expect_reg("software clear", `OFS_INTERRUPT_STATUS, 32'h00000000);
    host.bus_write(`OFS_INTERRUPT_ENABLE, 32'hFFFFFFFF);
    expect_reg("enable mask", `OFS_INTERRUPT_ENABLE, `STATUS_READ_MASK);
    host.bus_write(`OFS_INTERRUPT_ENABLE, 32'h00024000);
    $display("test software event done");

    pulse(14);
    check("irq internal", {31'h0, o_irq_internal}, 32'h1);
    check("irq holdable", {31'h0, o_irq_holdable}, 32'h1);
    check("irq power", {31'h0, o_irq_power}, 32'h0);
    host.bus_write(`OFS_INTERRUPT_STATUS, 32'h00004000);
    pulse(17);
    check("irq power", {31'h0, o_irq_power}, 32'h1);
    check("irq holdable", {31'h0, o_irq_holdable}, 32'h0);
    check("no wake", {31'h0, o_wake}, 32'h0);
    host.bus_write(`OFS_INTERRUPT_STATUS, 32'h00020000);
    #1;
    check("irq idle", {31'h0, o_irq_internal}, 32'h0);
    $display("test interrupt lines done");

    fork
      host.bus_write(`OFS_INTERRUPT_STATUS, 32'h00004000);
      pulse(14);
    join
    expect_reg("set wins", `OFS_INTERRUPT_STATUS, 32'h00004000);
    host.bus_write(`OFS_INTERRUPT_STATUS, 32'h00004000);
    expect_reg("cleared", `OFS_INTERRUPT_STATUS, 32'h00000000);
    $display("test set over clear done");

    pulse(6);
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    expect_reg("reset status", `OFS_INTERRUPT_STATUS, 32'h00000000);
    expect_reg("reset enable", `OFS_INTERRUPT_ENABLE, 32'h00000000);
    $display("test mid-run reset done");

    host.bus_write(`OFS_BYTE_TEST, 32'h00000000);
    #1;
    check("wake pulse", {31'h0, o_wake}, 32'h1);
    @(posedge i_clk);
    #1;
    check("wake end", {31'h0, o_wake}, 32'h0);
    expect_reg("byte test", `OFS_BYTE_TEST, 32'h87654321);
    $display("test wake done");
    end_sim();
  end

endmodule
